// file: hdl/asfc_fifo_control.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// [R1] Threshold is 9 bits: low byte plus config bit, range 0 to 511.
// [R2] Threshold counts sample sets; each set holds one entry per channel.
// [R3] Threshold low byte resets to 0x80.
// [R4] Host changes mode only in standby.
// [R5] Host passes through disabled mode between active modes.
// [R6] Disabled mode stores nothing.
// [R7] Oldest-saved mode fills until full, then stops.
// [R8] Oldest-saved mode resumes once host reads entries out.
// [R9] Stream mode drops the oldest entry to make room.
// [R10] Stream mode raises threshold event at the programmed set count.
// [R11] Triggered mode keeps programmed pre-event samples, single shot.
// [R12] Triggered mode raises threshold event once required samples stored.
// [R13] Triggered mode rearms threshold event only after a host read.
// [R14] Host never programs channel code 1111.
// [R15] Default channel code stores x, y and z per set.
// [R16] Oldest-saved mode discards incoming samples while full.
module asfc_fifo_control #(
	parameter int DEPTH = asfc_pkg::DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire asfc_pkg::asfc_sample_type sample_in,
	input wire logic activity_event,
	input wire logic standby,
	output logic irq,
	output logic threshold_reached_flag
);
	localparam int AW = asfc_pkg::AW;
	// Pointers wrap at 2**PW, which is the array size only when DEPTH is a power of two
	localparam int PW = $clog2(DEPTH);
	logic rst_meta, rst_n;
	logic [7:0] thr_low;
	asfc_pkg::asfc_cfg_type cfg;
	logic [2:0] status, mask;
	logic [15:0] mem [DEPTH];
	logic [PW-1:0] wptr, rptr;
	logic [AW-1:0] level;
	logic [15:0] data_out;
	logic [8:0] thr;
	// Two spare bits: 511 sets of three entries exceed the level width
	logic [AW+1:0] thr_entries;
	logic [1:0] per_set;
	logic set_end;
	logic full, empty;
	logic store, drop, pop;
	logic trig_armed, triggered, post_done, event_done;
	logic [AW-1:0] post_count;
	logic thresh_evt, overrun_evt;
	logic rd_status, wr_control;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	asfc_set_counter u_set (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.chan(cfg.chan),
		.step(store),
		.entries_per_set(per_set),
		.set_end(set_end)
	);

	always_comb begin
		thr = {cfg.thr_msb, thr_low}; // [R1]
		thr_entries = (AW+2)'(thr) * (AW+2)'(per_set); // [R2] [R15]
		full = (level == AW'(DEPTH));
		empty = (level == '0);
		pop = reg_rd && (reg_addr == asfc_pkg::OFS_DATA) && !empty;
		rd_status = reg_rd && (reg_addr == asfc_pkg::OFS_STATUS);
		wr_control = reg_wr && (reg_addr == asfc_pkg::OFS_CONTROL);
		store = 1'b0;
		drop = 1'b0;
		unique case (cfg.mode)
			asfc_pkg::ASFC_MODE_OFF: store = 1'b0; // [R6]
			asfc_pkg::ASFC_MODE_OLDEST: store = sample_in.valid && (!full || pop); // [R7] [R8] [R16]
			asfc_pkg::ASFC_MODE_STREAM: begin
				store = sample_in.valid;
				drop = sample_in.valid && full && !pop; // [R9]
			end
			asfc_pkg::ASFC_MODE_TRIG: begin
				store = sample_in.valid && !post_done; // [R11]
				drop = sample_in.valid && !triggered && !pop && (level >= thr_entries)
					&& !empty; // [R11]
			end
		endcase
		overrun_evt = sample_in.valid && full && !pop && (cfg.mode == asfc_pkg::ASFC_MODE_OLDEST);
	end

	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_low <= asfc_pkg::THR_LOW_RST; // [R3]
			cfg <= asfc_pkg::asfc_cfg_type'(asfc_pkg::CONFIG_RST);
			mask <= 3'h0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				asfc_pkg::OFS_THR_LOW: thr_low <= reg_wdata;
				asfc_pkg::OFS_CONFIG: begin
					// Mode changes are only honoured in standby, protecting a live capture
					cfg.chan <= reg_wdata[asfc_pkg::CFG_CHAN_LSB +: 4];
					cfg.thr_msb <= reg_wdata[asfc_pkg::CFG_THR_MSB];
					if (standby) begin
						cfg.mode <= asfc_pkg::asfc_mode_type'(reg_wdata[1:0]); // [R4]
					end
				end
				asfc_pkg::OFS_MASK: mask <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// Storage
	always_ff @(posedge sys_clk) begin
		if (store) begin
			mem[wptr] <= sample_in.data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr <= '0;
			rptr <= '0;
			level <= '0;
			data_out <= 16'h0000;
		end else if (cfg.mode == asfc_pkg::ASFC_MODE_OFF) begin
			wptr <= '0;
			rptr <= '0;
			level <= '0;
		end else begin
			if (store) begin
				wptr <= wptr + PW'(1);
			end
			if (pop || drop) begin
				rptr <= rptr + PW'(1);
				data_out <= mem[rptr];
			end
			level <= level + AW'(store) - AW'(pop || drop);
		end
	end

	// Triggered capture sequencing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			triggered <= 1'b0;
			post_done <= 1'b0;
			post_count <= '0;
		end else if (cfg.mode != asfc_pkg::ASFC_MODE_TRIG) begin
			triggered <= 1'b0;
			post_done <= 1'b0;
			post_count <= '0;
		end else begin
			if (activity_event && !triggered) begin
				triggered <= 1'b1; // [R11]
			end
			if (triggered && store && !post_done) begin
				post_count <= post_count + 1'b1;
				if (post_count + 1'b1 >= AW'(DEPTH) - thr_entries || level + 1'b1 >= AW'(DEPTH)) begin
					post_done <= 1'b1; // [R11]
				end
			end
		end
	end

	// Threshold event: one per host read in triggered mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_armed <= 1'b1;
		end else if (pop) begin
			trig_armed <= 1'b1; // [R13]
		end else if (cfg.mode == asfc_pkg::ASFC_MODE_TRIG && thresh_evt) begin
			trig_armed <= 1'b0; // [R13]
		end
	end

	always_comb begin
		event_done = post_done && (cfg.mode == asfc_pkg::ASFC_MODE_TRIG);
		unique case (cfg.mode)
			asfc_pkg::ASFC_MODE_TRIG: thresh_evt = event_done && trig_armed; // [R12]
			asfc_pkg::ASFC_MODE_OFF: thresh_evt = 1'b0;
			default: thresh_evt = (level >= thr_entries) && !(empty && thr == 9'h000)
				&& !threshold_reached_flag; // [R10]
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			threshold_reached_flag <= 1'b0;
		end else if (cfg.mode == asfc_pkg::ASFC_MODE_TRIG) begin
			threshold_reached_flag <= event_done;
		end else begin
			threshold_reached_flag <= (cfg.mode != asfc_pkg::ASFC_MODE_OFF)
				&& (level >= thr_entries) && (thr != 9'h000); // [R10]
		end
	end

	// Sticky status: set wins over clear-on-read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= 3'h0;
		end else begin
			status <= (rd_status ? 3'h0 : status)
				| {activity_event && !triggered && cfg.mode == asfc_pkg::ASFC_MODE_TRIG,
				overrun_evt, thresh_evt};
		end
	end

	assign irq = |(status & mask);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				asfc_pkg::OFS_THR_LOW: reg_rdata <= thr_low;
				asfc_pkg::OFS_CONFIG: reg_rdata <= {1'b0, cfg};
				asfc_pkg::OFS_STATUS: reg_rdata <= {5'h00, status};
				asfc_pkg::OFS_MASK: reg_rdata <= {5'h00, mask};
				asfc_pkg::OFS_LEVEL_LO: reg_rdata <= level[7:0];
				asfc_pkg::OFS_LEVEL_HI: reg_rdata <= {6'h00, level[AW-1:8]};
				asfc_pkg::OFS_DATA: reg_rdata <= empty ? 8'h00 : mem[rptr][7:0];
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Checks
	property p_reset_thr;
		@(posedge sys_clk) $rose(rst_n) |-> thr_low == asfc_pkg::THR_LOW_RST;
	endproperty
	thr_reset_a: assert property (p_reset_thr) else $error("threshold low not at reset value"); // [R3]

	off_no_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_OFF |=> level == '0) else $error("level nonzero when off"); // [R6]

	oldest_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_OLDEST && full && !pop && !wr_control
		&& $stable(cfg.mode) |=> full) else $error("oldest mode lost full"); // [R7] [R16]

	oldest_resume_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_OLDEST && full && pop && sample_in.valid |-> store)
		else $error("oldest mode did not resume"); // [R8]

	stream_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_STREAM && full && sample_in.valid && !reg_wr
		|=> full) else $error("stream mode not kept full"); // [R9]

	stream_thresh_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_STREAM && level >= thr_entries && thr != 9'h000
		&& $stable(cfg) |=> threshold_reached_flag) else $error("threshold flag missing"); // [R10]

	sequence s_fired;
		cfg.mode == asfc_pkg::ASFC_MODE_TRIG && thresh_evt && !pop;
	endsequence
	trig_single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_fired ##1 !pop |-> !thresh_evt) else $error("second trigger event without read"); // [R12] [R13]

	thr_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		thr == {cfg.thr_msb, thr_low} && thr <= 9'h1ff) else $error("threshold width wrong"); // [R1]

	xyz_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.chan == asfc_pkg::CHAN_XYZ |-> per_set == 2'h3) else $error("default not three axes"); // [R2] [R15]

	mode_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!standby |=> $stable(cfg.mode)) else $error("mode changed outside standby"); // [R4]

	off_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.mode == asfc_pkg::ASFC_MODE_OFF |=> !threshold_reached_flag)
		else $error("threshold flag while disabled"); // [R6]

	// A status read with no event beside it must leave every sticky bit clear
	sequence s_quiet_read;
		rd_status && !thresh_evt && !overrun_evt && !activity_event;
	endsequence
	status_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_quiet_read |=> status == 3'h0) else $error("status not cleared by read");

	rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero when idle");

	// An empty read must not pop, or the level would wrap below zero
	sequence s_empty_read;
		reg_rd && reg_addr == asfc_pkg::OFS_DATA && empty && !store;
	endsequence
	empty_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_empty_read |=> level == '0) else $error("empty read changed level");
endmodule

// file: hdl/asfc_set_counter.sv
`timescale 1ns/1ps
// Counts channel entries within one sample set and flags the set boundary
module asfc_set_counter (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] chan,
	input wire logic step,
	output logic [1:0] entries_per_set,
	output logic set_end
);
	logic [1:0] idx;

	function automatic logic [1:0] asfc_entries(input logic [3:0] c);
		unique case (c[1:0])
			2'b00: asfc_entries = 2'h3;
			default: asfc_entries = 2'h1;
		endcase
	endfunction

	always_comb begin
		entries_per_set = asfc_entries(chan);
		set_end = step && (idx == entries_per_set - 2'h1);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx <= 2'h0;
		end else if (set_end) begin
			idx <= 2'h0;
		end else if (step) begin
			idx <= idx + 2'h1;
		end
	end
endmodule

// file: pkg/asfc_pkg.sv
package asfc_pkg;
	localparam int DEPTH = 512;
	localparam int AW = 10;
	// Register offsets
	localparam logic [7:0] OFS_THR_LOW = 8'h29;
	localparam logic [7:0] OFS_CONFIG = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_MASK = 8'h31;
	localparam logic [7:0] OFS_LEVEL_LO = 8'h32;
	localparam logic [7:0] OFS_LEVEL_HI = 8'h33;
	localparam logic [7:0] OFS_DATA = 8'h34;
	localparam logic [7:0] OFS_CONTROL = 8'h35;
	// Reset values
	localparam logic [7:0] THR_LOW_RST = 8'h80;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	// Config fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_THR_MSB = 2;
	localparam int CFG_CHAN_LSB = 3;
	// Status bits and channel codes
	localparam int ST_THRESH = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_TRIGGERED = 2;
	localparam logic [3:0] CHAN_XYZ = 4'h0;
	localparam logic [3:0] CHAN_RESERVED = 4'hf;

	typedef enum logic [1:0] {
		ASFC_MODE_OFF = 2'b00,
		ASFC_MODE_OLDEST = 2'b01,
		ASFC_MODE_STREAM = 2'b10,
		ASFC_MODE_TRIG = 2'b11
	} asfc_mode_type;

	typedef struct packed {
		logic [3:0] chan;
		logic thr_msb;
		asfc_mode_type mode;
	} asfc_cfg_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} asfc_sample_type;
endpackage

// file: verif/asfc_fifo_control_bench.sv
`timescale 1ns/1ps
module asfc_fifo_control_bench;
	logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, send = 0, act = 0, standby = 1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic irq, flag;
	asfc_pkg::asfc_sample_type smp;
	int seed = 2186, bad_count = 0, cmp_count = 0, sent = 0, n, base;
	always #20 sys_clk = ~sys_clk;
	asfc_sensor_model sen (.sys_clk(sys_clk), .send(send), .sample(smp));
	asfc_fifo_control #(.DEPTH(16)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_in(smp), .activity_event(act), .standby(standby),
		.irq(irq), .threshold_reached_flag(flag));
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge sys_clk) begin
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1;
		end
		@(posedge sys_clk) reg_wr <= 0;
		// Let the written value settle before any level is looked at
		@(negedge sys_clk);
	endtask
	task automatic rdc(string nm, logic [7:0] a, logic [7:0] e);
		@(posedge sys_clk) begin
			reg_addr <= a;
			reg_rd <= 1;
		end
		@(posedge sys_clk) reg_rd <= 0;
		// Data stands only in this cycle, so take it mid-cycle
		@(negedge sys_clk) d = reg_rdata;
		chk(nm, e, d);
	endtask
	task automatic push(int k);
		repeat (k) begin
			@(posedge sys_clk) send <= 1;
			sent++;
		end
		@(posedge sys_clk) send <= 0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1;
		repeat (4) @(posedge sys_clk);
		rdc("thr_low", asfc_pkg::OFS_THR_LOW, 8'h80);
		rdc("config", asfc_pkg::OFS_CONFIG, 8'h00);
		standby <= 0;
		wr(asfc_pkg::OFS_CONFIG, 8'h01);
		rdc("config_locked", asfc_pkg::OFS_CONFIG, 8'h00);
		standby <= 1;
		$display("test reset done");
		wr(asfc_pkg::OFS_THR_LOW, 8'h02);
		wr(asfc_pkg::OFS_CONFIG, 8'h01);
		wr(asfc_pkg::OFS_MASK, 8'h01);
		push(5);
		chk("flag_below", 8'h00, {7'h00, flag});
		push(1);
		chk("flag_at", 8'h01, {7'h00, flag});
		chk("irq_on", 8'h01, {7'h00, irq});
		wr(asfc_pkg::OFS_MASK, 8'h00);
		chk("irq_masked", 8'h00, {7'h00, irq});
		push(12);
		rdc("level_full", asfc_pkg::OFS_LEVEL_LO, 8'h10);
		rdc("level_hi", asfc_pkg::OFS_LEVEL_HI, 8'h00);
		rdc("status", asfc_pkg::OFS_STATUS, 8'h03);
		wr(asfc_pkg::OFS_MASK, 8'h03);
		chk("irq_cleared", 8'h00, {7'h00, irq});
		rdc("oldest_kept", asfc_pkg::OFS_DATA, 8'h00);
		rdc("level_pop", asfc_pkg::OFS_LEVEL_LO, 8'h0f);
		push(2);
		rdc("level_refill", asfc_pkg::OFS_LEVEL_LO, 8'h10);
		$display("test oldest done");
		wr(asfc_pkg::OFS_CONFIG, 8'h00);
		push(2);
		rdc("level_off", asfc_pkg::OFS_LEVEL_LO, 8'h00);
		wr(asfc_pkg::OFS_CONFIG, 8'h02);
		base = sent;
		n = 20 + ($random(seed) & 7);
		push(n);
		chk("flag_stream", 8'h01, {7'h00, flag});
		rdc("level_stream", asfc_pkg::OFS_LEVEL_LO, 8'h10);
		rdc("newest_kept", asfc_pkg::OFS_DATA, 8'(base + n - 16));
		wr(asfc_pkg::OFS_CONFIG, 8'h06);
		repeat (3) @(negedge sys_clk);
		chk("flag_msb", 8'h00, {7'h00, flag});
		rdc("status_stream", asfc_pkg::OFS_STATUS, 8'h03);
		$display("test stream done");
		wr(asfc_pkg::OFS_CONFIG, 8'h00);
		wr(asfc_pkg::OFS_THR_LOW, 8'h01);
		wr(asfc_pkg::OFS_CONFIG, 8'h03);
		push(5);
		rdc("level_pre", asfc_pkg::OFS_LEVEL_LO, 8'h03);
		chk("flag_pre", 8'h00, {7'h00, flag});
		@(posedge sys_clk) act <= 1;
		@(posedge sys_clk) act <= 0;
		push(16);
		rdc("level_trig", asfc_pkg::OFS_LEVEL_LO, 8'h10);
		chk("flag_trig", 8'h01, {7'h00, flag});
		rdc("status_trig", asfc_pkg::OFS_STATUS, 8'h05);
		$display("test triggered done");
		final_report();
	end
endmodule

// file: verif/asfc_sensor_model.sv
`timescale 1ns/1ps
// Sample source beside the FIFO: one channel entry per cycle while send is high
module asfc_sensor_model (
	input wire logic sys_clk,
	input wire logic send,
	output asfc_pkg::asfc_sample_type sample
);
	logic [15:0] cnt;
	initial begin
		cnt = 16'h0000;
		sample = '0;
	end
	always @(posedge sys_clk) begin
		sample.valid <= send;
		if (send) begin
			sample.data <= cnt;
			cnt <= cnt + 16'h0001;
		end else begin
			// Idle bus toggles so a stale word is never mistaken for data
			sample.data <= ~sample.data;
		end
	end
endmodule
